// >>> logic/psr_link_if.sv
// two-wire link between bus master and pressure sensor
`timescale 1ns/1ps
`default_nettype none
interface psr_link_if;
   logic m_scl_out;   // master clock drive value
   logic m_scl_oe_n;  // master clock enable, low drives
   logic m_sda_out;   // master data drive value
   logic m_sda_oe_n;  // master data enable, low drives
   logic s_sda_out;   // sensor data drive value
   logic s_sda_oe_n;  // sensor data enable, low drives
   logic scl;         // resolved clock line
   logic sda;         // resolved data line

   // wired-and with pull-ups: a line is low only where someone pulls it
   assign scl = m_scl_oe_n | m_scl_out;
   assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

   modport master (output m_scl_out, m_scl_oe_n, m_sda_out, m_sda_oe_n,
                   input scl, sda);
   modport sensor (output s_sda_out, s_sda_oe_n,
                   input scl, sda);
endinterface
`default_nettype wire

// >>> logic/psr_master.sv
// bus master end: makes the serial clock and reads the pressure
`timescale 1ns/1ps
`default_nettype none
module psr_master (
   input  wire logic        sys_clk_in,  // system clock, 100 MHz
   input  wire logic        nrst_in,     // async reset, active low
   input  wire logic        rd_req_in,   // level: read wanted
   input  wire logic [6:0]  addr_in,     // target address
   input  wire logic        chain_in,    // repeated start if next read pending
   output logic             busy_out,    // frame in progress
   output logic             done_out,    // pulse: read finished
   output logic             nack_out,    // pulse: address not acknowledged
   output logic      [15:0] data_out,    // last reading, high byte first
   psr_link_if.master       link         // two-wire link
);

   // ----------------------------------------------------------------
   // quarter-bit timebase and pin sampling
   // ----------------------------------------------------------------
   psr_pkg::psr_ms_state_t state_q;
   logic [psr_pkg::QCNT_W-1:0] qcnt_q;
   logic [1:0]  q_q;
   logic [2:0]  bit_q;
   logic        byte_q;
   logic [7:0]  sh_q;
   logic [15:0] data_q;
   logic        scl_low_q;
   logic        sda_low_q;
   logic        sda_s1_q;
   logic        sda_s2_q;
   logic        done_q;
   logic        nack_q;
   logic        qtick;
   logic        slot_end;
   logic        again;

   assign qtick    = (qcnt_q == psr_pkg::QCNT_W'(psr_pkg::SCL_QUARTER - 1));
   assign slot_end = qtick && (q_q == 2'h3);
   assign again    = chain_in && rd_req_in;

   // data line through two flops before use
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         qcnt_q   <= '0;
         q_q      <= 2'h0;
      end else begin
         sda_s1_q <= link.sda;
         sda_s2_q <= sda_s1_q;
         qcnt_q   <= qtick ? '0 : qcnt_q + 1'b1;
         q_q      <= qtick ? q_q + 2'h1 : q_q;
      end
   end

   // ----------------------------------------------------------------
   // frame sequencer: q0 low/set data, q1 rise, q2 high, q3 sample
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q   <= psr_pkg::MS_IDLE;
         bit_q     <= psr_pkg::BIT_FIRST;
         byte_q    <= psr_pkg::BYTE_HI;
         sh_q      <= 8'h00;
         data_q    <= 16'h0000;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         done_q    <= 1'b0;
         nack_q    <= 1'b0;
      end else begin
         done_q <= 1'b0;
         nack_q <= 1'b0;
         if (qtick) begin
            // clock line: low for the first half of every slot, second quarter only in a start after idle, stays high after stop
            scl_low_q <= (state_q != psr_pkg::MS_IDLE) && (q_q == 2'h3 || q_q == 2'h0)
                         && !(state_q == psr_pkg::MS_STOP && q_q != 2'h0);
            case (state_q)
               psr_pkg::MS_IDLE: begin
                  sda_low_q <= 1'b0;
                  if (rd_req_in && q_q == 2'h3) begin
                     state_q <= psr_pkg::MS_START;
                  end
               end
               psr_pkg::MS_START: begin
                  // data falls mid clock-high, never on a clock edge
                  if (q_q == 2'h2) sda_low_q <= 1'b1;
                  if (q_q == 2'h3) begin
                     state_q <= psr_pkg::MS_ADDR;
                     sh_q    <= {addr_in, psr_pkg::DIR_READ};
                     bit_q   <= psr_pkg::BIT_FIRST;
                  end
               end
               psr_pkg::MS_ADDR: begin
                  if (q_q == 2'h0) sda_low_q <= ~sh_q[psr_pkg::BIT_LAST - bit_q];
                  if (q_q == 2'h3) begin
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == psr_pkg::BIT_LAST) state_q <= psr_pkg::MS_ADDR_ACK;
                  end
               end
               psr_pkg::MS_ADDR_ACK: begin
                  if (q_q == 2'h0) sda_low_q <= 1'b0;
                  if (q_q == 2'h3) begin
                     bit_q  <= psr_pkg::BIT_FIRST;
                     byte_q <= psr_pkg::BYTE_HI;
                     if (sda_s2_q) begin
                        nack_q  <= 1'b1;
                        state_q <= psr_pkg::MS_STOP;
                     end else begin
                        state_q <= psr_pkg::MS_RD;
                     end
                  end
               end
               psr_pkg::MS_RD: begin
                  if (q_q == 2'h0) sda_low_q <= 1'b0;
                  if (q_q == 2'h3) begin
                     sh_q  <= {sh_q[6:0], sda_s2_q};
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == psr_pkg::BIT_LAST) state_q <= psr_pkg::MS_RD_ACK;
                  end
               end
               psr_pkg::MS_RD_ACK: begin
                  if (q_q == 2'h0) sda_low_q <= (byte_q == psr_pkg::BYTE_HI);
                  if (q_q == 2'h3) begin
                     bit_q <= psr_pkg::BIT_FIRST;
                     if (byte_q == psr_pkg::BYTE_HI) begin
                        data_q[15:8] <= sh_q;
                        byte_q       <= psr_pkg::BYTE_LO;
                        state_q      <= psr_pkg::MS_RD;
                     end else begin
                        data_q[7:0] <= sh_q;
                        done_q      <= 1'b1;
                        state_q     <= again ? psr_pkg::MS_START : psr_pkg::MS_STOP;
                     end
                  end
               end
               psr_pkg::MS_STOP: begin
                  if (q_q == 2'h0) sda_low_q <= 1'b1;
                  if (q_q == 2'h2) sda_low_q <= 1'b0;
                  if (q_q == 2'h3) state_q <= psr_pkg::MS_IDLE;
               end
               default: begin
                  state_q <= psr_pkg::MS_IDLE;
               end
            endcase
         end
      end
   end

   // open-drain drives: enable low while pulling the line
   assign link.m_scl_out  = 1'b0;
   assign link.m_scl_oe_n = ~scl_low_q;
   assign link.m_sda_out  = 1'b0;
   assign link.m_sda_oe_n = ~sda_low_q;

   assign busy_out = (state_q != psr_pkg::MS_IDLE);
   assign done_out = done_q;
   assign nack_out = nack_q;
   assign data_out = data_q;

endmodule
`default_nettype wire

// >>> logic/psr_pkg.sv
// shared constants and types for the pressure readout link
package psr_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ     = 100_000_000;
   localparam int unsigned CONV_PERIOD_US = 500;
   localparam int unsigned CONV_CYCLES    = (SYS_CLK_HZ / 1_000_000) * CONV_PERIOD_US;
   localparam int unsigned SCL_HZ         = 100_000;
   localparam int unsigned SCL_HZ_MAX     = 400_000;
   localparam int unsigned SCL_QUARTER    = SYS_CLK_HZ / (4 * SCL_HZ);
   localparam int unsigned QCNT_W         = 10;

   // ----------------------------------------------------------------
   // addressing and framing
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_PRIMARY = 7'h78;
   localparam logic       DIR_READ     = 1'h1;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [2:0] BIT_FIRST    = 3'h0;
   localparam logic       BYTE_HI      = 1'h0;
   localparam logic       BYTE_LO      = 1'h1;

   // ----------------------------------------------------------------
   // reading scale
   // ----------------------------------------------------------------
   localparam int unsigned CODE_W          = 13;
   localparam int unsigned VAL_W           = 15;
   localparam logic [14:0] ZERO_COUNTS     = 15'h0CCD;
   localparam logic [14:0] full_scale_span = 15'h6666;
   localparam logic [14:0] RESET_VALUE     = 15'h0CCD;

   // ----------------------------------------------------------------
   // state machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SN_IDLE     = 3'h0,
      SN_ADDR     = 3'h1,
      SN_ADDR_ACK = 3'h2,
      SN_WR       = 3'h3,
      SN_WR_ACK   = 3'h4,
      SN_TX       = 3'h5,
      SN_TX_ACK   = 3'h6
   } psr_sn_state_t;

   typedef enum logic [2:0] {
      MS_IDLE     = 3'h0,
      MS_START    = 3'h1,
      MS_ADDR     = 3'h2,
      MS_ADDR_ACK = 3'h3,
      MS_RD       = 3'h4,
      MS_RD_ACK   = 3'h5,
      MS_STOP     = 3'h6
   } psr_ms_state_t;

endpackage

// >>> logic/psr_sensor.sv
// pressure sensor end: conversion cycle and two-wire slave readout
//
// What this block does
// - refresh corrected 15-bit reading every 500 us
// - slave only, never drives clock or conditions
// - both lines rest high when idle
// - falling data with clock high is start
// - rising data with clock high ends transaction
// - repeated starts chain requests without stop
// - data changes only while clock low
// - eight-bit bytes, most significant bit first
// - receiver acknowledges each byte on ninth clock, except the master on the last read byte
// - missing acknowledge stops sensor transmitting
// - answers fixed address 1111000 plus direction
// - optional secondary address also answered
// - first byte is address and direction bit
// - read returns two bytes of current reading
// - reading spans 3277 to 29491 counts nominally
// - master clocks bus between 100 and 400 kHz
`timescale 1ns/1ps
`default_nettype none
module psr_sensor #(
   parameter int unsigned CONV_CYCLES  = psr_pkg::CONV_CYCLES,  // refresh interval in cycles
   parameter bit          SEC_ADDR_EN  = 1'b0,                  // secondary address fitted
   parameter logic [6:0]  SEC_ADDR     = 7'h00                  // secondary address value
) (
   input  wire logic        sys_clk_in,        // conversion clock, 100 MHz
   input  wire logic        nrst_in,           // async reset, active low
   input  wire logic [12:0] pressure_code_in,  // raw converter code
   output logic      [14:0] reading_out,       // latest corrected reading
   output logic             refresh_out,       // pulse per new reading
   psr_link_if.sensor       link               // two-wire link
);

   // ----------------------------------------------------------------
   // conversion cycle (system domain)
   // ----------------------------------------------------------------
   logic [31:0] conv_cnt_q;
   logic [31:0] conv_cnt_d;
   logic        conv_tick;
   logic [27:0] scaled;
   logic [14:0] corrected;
   logic [14:0] reading_q;
   logic        refresh_q;
   logic [14:0] hold_q;
   logic        req_tg_q;
   logic        ack_s1_q;
   logic        ack_s2_q;
   logic        ack_tg_q;
   logic        handoff_free;

   // interval counter wraps at the refresh period
   assign conv_tick  = (conv_cnt_q == CONV_CYCLES - 1);
   assign conv_cnt_d = conv_tick ? '0 : conv_cnt_q + 32'h1;

   // linear map of code onto the nominal span above zero counts
   assign scaled    = {15'h0, pressure_code_in} * {13'h0, psr_pkg::full_scale_span};
   assign corrected = psr_pkg::ZERO_COUNTS + scaled[27:13];

   // link side has taken the last hand-off once its ack matches
   assign handoff_free = (ack_s2_q == req_tg_q);

   // refresh output registers every interval
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         conv_cnt_q <= '0;
         reading_q  <= psr_pkg::RESET_VALUE;
         refresh_q  <= 1'b0;
      end else begin
         conv_cnt_q <= conv_cnt_d;
         refresh_q  <= conv_tick;
         if (conv_tick) begin
            reading_q <= corrected;
         end
      end
   end

   // offer the newest reading to the link side by toggle handshake
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hold_q   <= psr_pkg::RESET_VALUE;
         req_tg_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tg_q;
         ack_s2_q <= ack_s1_q;
         if (handoff_free && hold_q != reading_q) begin
            hold_q   <= reading_q;
            req_tg_q <= ~req_tg_q;
         end
      end
   end

   assign reading_out = reading_q;
   assign refresh_out = refresh_q;

   // ----------------------------------------------------------------
   // start and stop detection (data line edges)
   // ----------------------------------------------------------------
   logic start_tg_q;
   logic stop_tg_q;

   // data falls while clock high: start
   always_ff @(negedge link.sda or negedge nrst_in) begin
      if (!nrst_in) begin
         start_tg_q <= 1'b0;
      end else if (link.scl) begin
         start_tg_q <= ~start_tg_q;
      end
   end

   // data rises while clock high: stop
   always_ff @(posedge link.sda or negedge nrst_in) begin
      if (!nrst_in) begin
         stop_tg_q <= 1'b0;
      end else if (link.scl) begin
         stop_tg_q <= ~stop_tg_q;
      end
   end

   // ----------------------------------------------------------------
   // link domain, clocked by the master's serial clock
   // ----------------------------------------------------------------
   psr_pkg::psr_sn_state_t state_q;
   psr_pkg::psr_sn_state_t state_d;
   logic [2:0]  bit_q;
   logic [2:0]  bit_d;
   logic [7:0]  rx_q;
   logic [7:0]  rx_d;
   logic [7:0]  tx_q;
   logic [7:0]  tx_d;
   logic        byte_q;
   logic        byte_d;
   logic        start_seen_q;
   logic        stop_seen_q;
   logic        req_s1_q;
   logic        req_s2_q;
   logic [14:0] cur_q;
   logic [15:0] frame_word;
   logic        got_start;
   logic        got_stop;
   logic        byte_done;
   logic [6:0]  addr_rx;
   logic        addr_hit;
   logic        master_ack;
   logic        pull_low_q;
   logic        pull_low_d;

   // decoding of the bit just sampled
   assign got_start  = (start_tg_q != start_seen_q);
   assign got_stop   = (stop_tg_q != stop_seen_q);
   assign byte_done  = (bit_q == psr_pkg::BIT_LAST);
   assign addr_rx    = rx_q[6:0];
   assign addr_hit   = (addr_rx == psr_pkg::ADDR_PRIMARY)
                     | (SEC_ADDR_EN && addr_rx == SEC_ADDR);
   assign master_ack = ~link.sda;
   assign frame_word = {1'b0, cur_q};

   // next state on each rising clock edge
   always_comb begin
      state_d = state_q;
      bit_d   = bit_q;
      rx_d    = rx_q;
      tx_d    = tx_q;
      byte_d  = byte_q;
      if (got_start) begin
         // any start, repeated or not, opens a new address byte
         state_d = psr_pkg::SN_ADDR;
         bit_d   = 3'h1;
         rx_d    = {7'h0, link.sda};
      end else if (got_stop) begin
         // a stop closes whatever transfer was open
         state_d = psr_pkg::SN_IDLE;
      end else begin
         case (state_q)
            psr_pkg::SN_ADDR, psr_pkg::SN_WR: begin
               rx_d  = {rx_q[6:0], link.sda};
               bit_d = bit_q + 3'h1;
               if (byte_done) begin
                  if (state_q == psr_pkg::SN_WR) begin
                     state_d = psr_pkg::SN_WR_ACK;
                  end else if (addr_hit) begin
                     state_d = psr_pkg::SN_ADDR_ACK;
                  end
               end
            end
            psr_pkg::SN_ADDR_ACK: begin
               bit_d  = psr_pkg::BIT_FIRST;
               byte_d = psr_pkg::BYTE_HI;
               if (rx_q[0] == psr_pkg::DIR_READ) begin
                  state_d = psr_pkg::SN_TX;
                  tx_d    = frame_word[15:8];
               end else begin
                  state_d = psr_pkg::SN_WR;
               end
            end
            psr_pkg::SN_WR_ACK: begin
               state_d = psr_pkg::SN_WR;
               bit_d   = psr_pkg::BIT_FIRST;
            end
            psr_pkg::SN_TX: begin
               bit_d = bit_q + 3'h1;
               if (byte_done) begin
                  state_d = psr_pkg::SN_TX_ACK;
               end
            end
            psr_pkg::SN_TX_ACK: begin
               bit_d = psr_pkg::BIT_FIRST;
               if (master_ack && byte_q == psr_pkg::BYTE_HI) begin
                  state_d = psr_pkg::SN_TX;
                  byte_d  = psr_pkg::BYTE_LO;
                  tx_d    = frame_word[7:0];
               end else begin
                  state_d = psr_pkg::SN_IDLE;
               end
            end
            default: begin
               state_d = psr_pkg::SN_IDLE;
            end
         endcase
      end
      if (state_q == psr_pkg::SN_ADDR && byte_done && !got_start && !addr_hit) begin
         state_d = psr_pkg::SN_IDLE;
      end
   end

   // link state registers
   always_ff @(posedge link.scl or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q      <= psr_pkg::SN_IDLE;
         bit_q        <= psr_pkg::BIT_FIRST;
         rx_q         <= 8'h00;
         tx_q         <= 8'h00;
         byte_q       <= psr_pkg::BYTE_HI;
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b0;
      end else begin
         state_q      <= state_d;
         bit_q        <= bit_d;
         rx_q         <= rx_d;
         tx_q         <= tx_d;
         byte_q       <= byte_d;
         start_seen_q <= start_tg_q;
         stop_seen_q  <= stop_tg_q;
      end
   end

   // take the offered reading; the clock only runs inside frames
   always_ff @(posedge link.scl or negedge nrst_in) begin
      if (!nrst_in) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         ack_tg_q <= 1'b0;
         cur_q    <= psr_pkg::RESET_VALUE;
      end else begin
         req_s1_q <= req_tg_q;
         req_s2_q <= req_s1_q;
         if (req_s2_q != ack_tg_q && state_q != psr_pkg::SN_TX_ACK
             && state_q != psr_pkg::SN_TX) begin
            cur_q    <= hold_q;
            ack_tg_q <= req_s2_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // data line drive, updated only while the clock is low
   // ----------------------------------------------------------------
   always_comb begin
      case (state_q)
         psr_pkg::SN_ADDR_ACK, psr_pkg::SN_WR_ACK: pull_low_d = 1'b1;
         psr_pkg::SN_TX:  pull_low_d = ~tx_q[psr_pkg::BIT_LAST - bit_q];
         default:         pull_low_d = 1'b0;
      endcase
   end

   // change the line on the falling clock edge
   always_ff @(negedge link.scl or negedge nrst_in) begin
      if (!nrst_in) begin
         pull_low_q <= 1'b0;
      end else begin
         pull_low_q <= pull_low_d;
      end
   end

   // open drain: only ever pulls data low, never touches the clock
   assign link.s_sda_out  = 1'b0;
   assign link.s_sda_oe_n = ~pull_low_q;

endmodule
`default_nettype wire

// >>> tb/pressure_sensor_i2c_readout_bench.sv
// self-checking bench for the pressure readout link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pressure_sensor_i2c_readout_bench;
   logic        sys_clk_in, nrst_in, rd_req_in, chain_in;
   logic [6:0]  addr_in;
   logic [12:0] pressure_code_in;
   logic [14:0] reading_out;
   logic        refresh_out, busy_out, done_out, nack_out;
   logic [15:0] data_out;
   int          n_errors, samples_checked, i, gap;
   psr_link_if link ();
   psr_sensor #(.CONV_CYCLES(200)) u_psr_sensor (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .pressure_code_in(pressure_code_in), .reading_out(reading_out),
      .refresh_out(refresh_out), .link(link));
   psr_master u_psr_master (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .rd_req_in(rd_req_in),
      .addr_in(addr_in), .chain_in(chain_in), .busy_out(busy_out), .done_out(done_out),
      .nack_out(nack_out), .data_out(data_out), .link(link));
   psr_link_checker u_psr_link_checker (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .m_sda_oe_n(link.m_sda_oe_n), .s_sda_oe_n(link.s_sda_oe_n), .scl(link.scl),
      .sda(link.sda));
   // -----------------------------------
   // helpers
   // -----------------------------------
   function automatic logic [14:0] exp_rd(input logic [12:0] c);
      return 15'(32'h0CCD + ((32'(c) * 32'h6666) >> 13));
   endfunction
   task automatic stop_test();
      $display("counts: errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // bounded wait for read end or refusal
   task automatic wait_end();
      for (i = 0; i < 40000 && done_out !== 1'b1 && nack_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 40000) begin
         n_errors++;
         stop_test();
      end
   endtask
   // refresh spacing and reading value
   task automatic chk_refresh();
      for (i = 0; i < 1000 && refresh_out !== 1'b1; i++) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      for (gap = 1; gap < 1000 && refresh_out !== 1'b1; gap++) @(negedge sys_clk_in);
      `CHK(gap, 200)
      `CHK(reading_out, exp_rd(pressure_code_in))
      $display("refresh test done");
   endtask
   task automatic read_one(input logic chain);
      rd_req_in = 1'b1;
      chain_in = chain;
      addr_in = psr_pkg::ADDR_PRIMARY;
      wait_end();
      `CHK(nack_out, 1'b0)
      rd_req_in = 1'b0;
      chain_in = 1'b0;
      @(negedge sys_clk_in);
      `CHK(data_out, {1'b0, exp_rd(pressure_code_in)})
      if (chain) begin
         `CHK(busy_out, 1'b1)
         wait_end();
         rd_req_in = 1'b0;
         chain_in = 1'b0;
         @(negedge sys_clk_in);
         `CHK(data_out, {1'b0, exp_rd(pressure_code_in)})
      end
      $display("read test done");
   endtask
   // -----------------------------------
   // clock and sequence
   // -----------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      nrst_in = 1'b0;
      rd_req_in = 1'b0;
      chain_in = 1'b0;
      addr_in = psr_pkg::ADDR_PRIMARY;
      pressure_code_in = 13'h1FFF;
      n_errors = 0;
      samples_checked = 0;
      i = $urandom(32'hC5229429);
      repeat (10) @(negedge sys_clk_in);
      nrst_in = 1'b1;
      // full-scale code, single read
      chk_refresh();
      read_one(1'b0);
      // foreign address is refused
      addr_in = 7'($urandom);
      if (addr_in == psr_pkg::ADDR_PRIMARY) addr_in = ~addr_in;
      rd_req_in = 1'b1;
      wait_end();
      `CHK(nack_out, 1'b1)
      rd_req_in = 1'b0;
      $display("refusal test done");
      // random code, two chained reads
      pressure_code_in = 13'($urandom);
      chk_refresh();
      read_one(1'b1);
      stop_test();
   end
endmodule
`default_nettype wire

// >>> tb/psr_link_checker.sv
// link protocol checker for the pressure readout
`timescale 1ns/1ps
`default_nettype none
module psr_link_checker (
   input wire logic sys_clk_in, // system clock
   input wire logic nrst_in,    // async reset
   input wire logic m_sda_oe_n, // master data enable
   input wire logic s_sda_oe_n, // sensor data enable
   input wire logic scl,        // clock line
   input wire logic sda         // data line
);
   logic       scl_q; // last clock level
   logic       sda_q; // last data level
   logic [4:0] bit_q; // clock rises since start
   logic [7:0] adr_q; // address byte
   logic [9:0] hi_q;  // clock high length
   // -----------------------------------
   // frame tracking
   // -----------------------------------
   wire start_w = scl & scl_q & sda_q & ~sda;
   wire rise_w  = scl & ~scl_q;
   wire match_w = adr_q[7:1] == psr_pkg::ADDR_PRIMARY;
   wire rd_w    = match_w & adr_q[0];
   // line history and counters
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_q <= 5'h00;
         adr_q <= 8'h00;
         hi_q  <= 10'h000;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         bit_q <= start_w ? 5'h00 : bit_q + 5'(rise_w);
         if (rise_w && bit_q < 5'h08) adr_q <= {adr_q[6:0], sda};
         hi_q  <= rise_w ? 10'h000 : hi_q + 10'(scl && hi_q != 10'h3FF);
      end
   end
   // -----------------------------------
   // assertions
   // -----------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   sns_edge_low_a: assert property ($changed(s_sda_oe_n) |-> !scl)
      else $error("sensor data moved with clock high");
   clk_high_min_a: assert property ($fell(scl) |-> hi_q >= 10'h03C)
      else $error("clock high phase too short");
   idle_high_a: assert property ($rose(nrst_in) |-> scl && sda)
      else $error("lines not idle high");
   addr_ack_a: assert property (rise_w && bit_q == 5'h08 && match_w |-> !s_sda_oe_n)
      else $error("address not acknowledged");
   foreign_quiet_a: assert property (rise_w && bit_q == 5'h08 && !match_w |-> s_sda_oe_n)
      else $error("sensor answered foreign address");
   pad_zero_a: assert property (rise_w && bit_q == 5'h09 && rd_w |-> !sda)
      else $error("upper data bit not zero");
   master_ack_a: assert property (rise_w && bit_q == 5'h11 && rd_w |-> !m_sda_oe_n)
      else $error("master missed first byte ack");
   master_nack_a: assert property (rise_w && bit_q == 5'h1A && rd_w |-> sda)
      else $error("last byte acknowledged");
   sns_quiet_a: assert property (bit_q == 5'h1B |-> s_sda_oe_n)
      else $error("sensor drove after nack");
   start_free_a: assert property (start_w |-> s_sda_oe_n && !m_sda_oe_n)
      else $error("start not made by master");
endmodule
`default_nettype wire
